// file: src/bcc_pkg.sv
// Purpose: Shared constants for the buck converter control register block.
// Assumes: 100 MHz clock, registers reached over the two-wire serial port.
// Notes: Voltage codes and ramp codes are raw register fields.
//
// Contract
// RULE_01 - Bit 7 of each main control register turns its converter on when set, off when clear.
// RULE_02 - Bit 6 of each main control register picks minimum ripple when set, efficiency when clear.
// RULE_03 - Bit 5 of each main control register forces fixed-frequency operation when set.
// RULE_04 - Bits 4 to 0 of each main control register hold the normal voltage code; a resets to 1.24 V.
// RULE_05 - Each idle voltage register holds the idle voltage code used only in idle; b resets to 1.8 V.
// RULE_06 - Bit 6 of each aux control register puts its converter into the idle state when set.
// RULE_07 - Bit 5 of each aux control register turns on the output discharge switch when set.
// RULE_08 - Bits 4 and 3 of the a aux register set the b clock phase delay of 0, 90, 180 or 270 degrees.
// RULE_09 - Bits 2 to 0 of the b aux register pick its ramp rate from 0.48 mV/us doubling, 111 immediate.
// RULE_10 - Bits 2 to 0 of the a aux register pick its ramp rate at half the b rate per code.
// RULE_11 - Voltage codes map linearly, a from 0.6 V by 40 mV, b from 1.0 V by 80 mV, all ones to lowest.
// RULE_12 - In the idle state a converter runs pulse-frequency and regulates to its idle voltage code.
// RULE_13 - A target change steps the output at the selected ramp rate, or in one step when immediate.
// RULE_14 - Unused register bits read as zero and ignore writes.
// RULE_15 - The host writes settings over the serial port and may read every register back.
package bcc_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_A_MAIN = 8'h10;
    localparam logic [7:0] ADDR_A_AUX = 8'h11;
    localparam logic [7:0] ADDR_A_IDLE = 8'h12;
    localparam logic [7:0] ADDR_B_MAIN = 8'h13;
    localparam logic [7:0] ADDR_B_AUX = 8'h14;
    localparam logic [7:0] ADDR_B_IDLE = 8'h15;

    // Writable bits per register; all others read zero.
    localparam logic [7:0] MASK_MAIN = 8'hFF;
    localparam logic [7:0] MASK_A_AUX = 8'h7F;
    localparam logic [7:0] MASK_B_AUX = 8'h67;
    localparam logic [7:0] MASK_IDLE = 8'h1F;

    // Reset values: converters off, a at 1.24 V, b at 1.8 V, fastest finite ramp.
    localparam logic [7:0] RST_A_MAIN = 8'h10;
    localparam logic [7:0] RST_A_AUX = 8'h16;
    localparam logic [7:0] RST_A_IDLE = 8'h10;
    localparam logic [7:0] RST_B_MAIN = 8'h0A;
    localparam logic [7:0] RST_B_AUX = 8'h06;
    localparam logic [7:0] RST_B_IDLE = 8'h0A;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int BIT_ON = 7;
    localparam int BIT_RIPPLE = 6;
    localparam int BIT_FIXED = 5;
    localparam int BIT_IDLE = 6;
    localparam int BIT_DISCH = 5;
    localparam int VCODE_MSB = 4;
    localparam int PHASE_MSB = 4;
    localparam int PHASE_LSB = 3;
    localparam int RATE_MSB = 2;

    localparam logic [4:0] VCODE_WRAP = 5'h1F;
    localparam logic [2:0] RATE_IMMEDIATE = 3'h7;

    // ----------------------------------------------------------------
    // Ramp timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int STEP_A_UV = 40000;
    localparam int STEP_B_UV = 80000;
    localparam int RATE_A_MIN_UV_PER_US = 240;
    localparam int RATE_B_MIN_UV_PER_US = 480;
    localparam int RAMP_A_CYCLES = STEP_A_UV * CLK_MHZ / RATE_A_MIN_UV_PER_US;
    localparam int RAMP_B_CYCLES = STEP_B_UV * CLK_MHZ / RATE_B_MIN_UV_PER_US;
    localparam int RAMP_CNT_W = 24;

    // ----------------------------------------------------------------
    // Serial slave states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SER_IDLE = 3'b000,
        SER_RX = 3'b001,
        SER_ACK = 3'b011,
        SER_TX = 3'b010,
        SER_RACK = 3'b110,
        SER_LOAD = 3'b111
    } bcc_ser_state_type;

    localparam logic [1:0] KIND_DEV = 2'h0;
    localparam logic [1:0] KIND_PTR = 2'h1;
    localparam logic [1:0] KIND_DATA = 2'h2;

endpackage

// file: src/bcc_serial_slave.sv
// Purpose: Two-wire serial slave giving byte writes and reads at a register pointer.
// Assumes: scl and sda come from pins; the register read data is combinational on ptr_q.
// Notes: No clock stretching; the pointer auto-increments after each written byte and each read byte the host acknowledges.
`timescale 1ns/1ps
module bcc_serial_slave #(
    parameter logic [6:0] DEV_ADDR = 7'h2A
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_oe_q,
    output logic [7:0] ptr_q,
    input wire logic [7:0] rd_data,
    output logic wr_en_q,
    output logic [7:0] wr_addr_q,
    output logic [7:0] wr_data_q
);
    import bcc_pkg::*;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0] scl_q;
    logic [2:0] sda_q;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            scl_q <= 3'h7;
            sda_q <= 3'h7;
        end else begin
            scl_q <= {scl_q[1:0], scl_in};
            sda_q <= {sda_q[1:0], sda_in};
        end
    end

    wire scl_rise = scl_q[1] & ~scl_q[2];
    wire scl_fall = ~scl_q[1] & scl_q[2];
    wire start_seen = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
    wire stop_seen = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];
    wire sda_bit = sda_q[1];

    // ----------------------------------------------------------------
    // Byte engine
    // ----------------------------------------------------------------
    bcc_ser_state_type state_q;
    logic [1:0] kind_q;
    logic [2:0] cnt_q;
    logic [7:0] sh_q;
    logic read_q;
    logic ack_phase_q;

    wire [7:0] rx_byte = {sh_q[6:0], sda_bit};
    wire byte_done = scl_rise & (cnt_q == 3'h7);

    // A write pulse and pointer increment share the cycle; the strobe keeps the old address.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_q <= SER_IDLE;
            kind_q <= KIND_DEV;
            cnt_q <= 3'h0;
            sh_q <= 8'h00;
            read_q <= 1'b0;
            ack_phase_q <= 1'b0;
            sda_oe_q <= 1'b0;
            ptr_q <= 8'h00;
            wr_en_q <= 1'b0;
            wr_addr_q <= 8'h00;
            wr_data_q <= 8'h00;
        end else begin
            wr_en_q <= 1'b0;
            if (start_seen) begin
                state_q <= SER_RX;
                kind_q <= KIND_DEV;
                cnt_q <= 3'h0;
                sda_oe_q <= 1'b0;
            end else if (stop_seen) begin
                state_q <= SER_IDLE;
                sda_oe_q <= 1'b0;
            end else begin
                case (state_q)
                    SER_RX: begin
                        if (scl_rise) begin
                            sh_q <= rx_byte;
                            cnt_q <= cnt_q + 3'h1;
                        end
                        if (byte_done) begin
                            ack_phase_q <= 1'b0;
                            state_q <= SER_ACK;
                            if (kind_q == KIND_DEV) begin
                                read_q <= rx_byte[0];
                                if (rx_byte[7:1] != DEV_ADDR) begin
                                    state_q <= SER_IDLE;
                                end
                            end else if (kind_q == KIND_PTR) begin
                                ptr_q <= rx_byte;
                            end else begin
                                wr_en_q <= 1'b1; // RULE_15
                                wr_addr_q <= ptr_q;
                                wr_data_q <= rx_byte;
                                ptr_q <= ptr_q + 8'h01;
                            end
                        end
                    end
                    SER_ACK: begin
                        if (scl_fall & ~ack_phase_q) begin
                            sda_oe_q <= 1'b1;
                            ack_phase_q <= 1'b1;
                        end else if (scl_fall) begin
                            cnt_q <= 3'h0;
                            if (read_q) begin
                                sh_q <= rd_data;
                                sda_oe_q <= ~rd_data[7];
                                state_q <= SER_TX;
                            end else begin
                                sda_oe_q <= 1'b0;
                                kind_q <= (kind_q == KIND_DEV) ? KIND_PTR : KIND_DATA;
                                state_q <= SER_RX;
                            end
                        end
                    end
                    SER_TX: begin
                        if (scl_fall & (cnt_q == 3'h7)) begin
                            sda_oe_q <= 1'b0;
                            state_q <= SER_RACK;
                        end else if (scl_fall) begin
                            sh_q <= {sh_q[6:0], 1'b0};
                            sda_oe_q <= ~sh_q[6];
                            cnt_q <= cnt_q + 3'h1;
                        end
                    end
                    SER_RACK: begin
                        if (scl_rise) begin
                            if (sda_bit) begin
                                state_q <= SER_IDLE;
                            end else begin
                                ptr_q <= ptr_q + 8'h01; // RULE_15
                                state_q <= SER_LOAD;
                            end
                        end
                    end
                    SER_LOAD: begin
                        if (scl_fall) begin
                            sh_q <= rd_data;
                            sda_oe_q <= ~rd_data[7];
                            cnt_q <= 3'h0;
                            state_q <= SER_TX;
                        end
                    end
                    default: begin
                        sda_oe_q <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule

// file: src/bcc_top.sv
// Purpose: Register file and output-voltage ramp control for two buck converters.
// Assumes: Host reaches the six registers through the serial slave.
// Notes: Voltage levels leave as ramped codes; the analog loops interpret them.
`timescale 1ns/1ps
module bcc_top #(
    parameter logic [6:0] DEV_ADDR = 7'h2A,
    parameter int RAMP_A_BASE_CYCLES = bcc_pkg::RAMP_A_CYCLES,
    parameter int RAMP_B_BASE_CYCLES = bcc_pkg::RAMP_B_CYCLES
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic buck_a_on,
    output logic buck_a_ripple_pref,
    output logic buck_a_force_fixed_freq,
    output logic buck_a_idle_select,
    output logic buck_a_discharge,
    output logic [4:0] buck_a_level,
    output logic buck_b_on,
    output logic buck_b_ripple_pref,
    output logic buck_b_force_fixed_freq,
    output logic buck_b_idle_select,
    output logic buck_b_discharge,
    output logic [4:0] buck_b_level,
    output logic [1:0] clock_phase_offset
);
    import bcc_pkg::*;

    // A smaller base would make the fastest finite ramp step on every clock or underflow.
    localparam int RAMP_BASE_MIN = 128;

    if (RAMP_A_BASE_CYCLES < RAMP_BASE_MIN || RAMP_A_BASE_CYCLES >= (1 << RAMP_CNT_W)) begin
        $error("RAMP_A_BASE_CYCLES out of range");
    end
    if (RAMP_B_BASE_CYCLES < RAMP_BASE_MIN || RAMP_B_BASE_CYCLES >= (1 << RAMP_CNT_W)) begin
        $error("RAMP_B_BASE_CYCLES out of range");
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // The all-ones code wraps to the bottom of the range, so it ramps as level zero.
    function automatic logic [4:0] code_to_level(input logic [4:0] code);
        code_to_level = (code == VCODE_WRAP) ? 5'h00 : code; // RULE_11
    endfunction

    function automatic logic [4:0] step_toward(input logic [4:0] cur, input logic [4:0] tgt);
        step_toward = (cur < tgt) ? cur + 5'h01 : cur - 5'h01;
    endfunction

    // Both ramp tables double per code, so the wait per code step halves per code.
    function automatic logic [RAMP_CNT_W-1:0] step_wait(input int base, input logic [2:0] rate);
        logic [RAMP_CNT_W-1:0] b;
        b = RAMP_CNT_W'(base);
        step_wait = (b >> rate) - RAMP_CNT_W'(1);
    endfunction

    // ----------------------------------------------------------------
    // Serial port
    // ----------------------------------------------------------------
    logic [7:0] ptr;
    logic [7:0] rd_data;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;

    bcc_serial_slave #(
        .DEV_ADDR(DEV_ADDR)
    ) u_serial (
        .clock(clock),
        .reset(reset),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_oe_q(sda_oe),
        .ptr_q(ptr),
        .rd_data(rd_data),
        .wr_en_q(wr_en),
        .wr_addr_q(wr_addr),
        .wr_data_q(wr_data)
    );

    // The pin is only ever pulled low, so its driven level is constant.
    assign sda_out = 1'b0;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0] a_main_q;
    logic [7:0] a_aux_q;
    logic [7:0] a_idle_q;
    logic [7:0] b_main_q;
    logic [7:0] b_aux_q;
    logic [7:0] b_idle_q;

    wire wr_a_main = wr_en & (wr_addr == ADDR_A_MAIN);
    wire wr_a_aux = wr_en & (wr_addr == ADDR_A_AUX);
    wire wr_a_idle = wr_en & (wr_addr == ADDR_A_IDLE);
    wire wr_b_main = wr_en & (wr_addr == ADDR_B_MAIN);
    wire wr_b_aux = wr_en & (wr_addr == ADDR_B_AUX);
    wire wr_b_idle = wr_en & (wr_addr == ADDR_B_IDLE);

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            a_main_q <= RST_A_MAIN; // RULE_04
            a_aux_q <= RST_A_AUX; // RULE_10
            a_idle_q <= RST_A_IDLE;
            b_main_q <= RST_B_MAIN;
            b_aux_q <= RST_B_AUX; // RULE_09
            b_idle_q <= RST_B_IDLE; // RULE_05
        end else begin
            if (wr_a_main) begin
                a_main_q <= wr_data & MASK_MAIN;
            end
            if (wr_a_aux) begin
                a_aux_q <= wr_data & MASK_A_AUX; // RULE_14
            end
            if (wr_a_idle) begin
                a_idle_q <= wr_data & MASK_IDLE; // RULE_14
            end
            if (wr_b_main) begin
                b_main_q <= wr_data & MASK_MAIN;
            end
            if (wr_b_aux) begin
                b_aux_q <= wr_data & MASK_B_AUX; // RULE_14
            end
            if (wr_b_idle) begin
                b_idle_q <= wr_data & MASK_IDLE; // RULE_14
            end
        end
    end

    // Unmapped pointer values read as zero.
    assign rd_data = (ptr == ADDR_A_MAIN) ? a_main_q :
                     (ptr == ADDR_A_AUX) ? a_aux_q :
                     (ptr == ADDR_A_IDLE) ? a_idle_q :
                     (ptr == ADDR_B_MAIN) ? b_main_q :
                     (ptr == ADDR_B_AUX) ? b_aux_q :
                     (ptr == ADDR_B_IDLE) ? b_idle_q : 8'h00; // RULE_15

    // ----------------------------------------------------------------
    // Target selection
    // ----------------------------------------------------------------
    wire a_idle = a_aux_q[BIT_IDLE]; // RULE_06
    wire b_idle = b_aux_q[BIT_IDLE]; // RULE_06
    wire [4:0] a_code = a_idle ? a_idle_q[VCODE_MSB:0] : a_main_q[VCODE_MSB:0]; // RULE_05
    wire [4:0] b_code = b_idle ? b_idle_q[VCODE_MSB:0] : b_main_q[VCODE_MSB:0]; // RULE_04
    wire [4:0] a_target = code_to_level(a_code); // RULE_11
    wire [4:0] b_target = code_to_level(b_code); // RULE_11
    wire [2:0] a_rate = a_aux_q[RATE_MSB:0]; // RULE_10
    wire [2:0] b_rate = b_aux_q[RATE_MSB:0]; // RULE_09

    // ----------------------------------------------------------------
    // Ramp engines
    // ----------------------------------------------------------------
    logic [4:0] a_level_q;
    logic [4:0] b_level_q;
    logic [RAMP_CNT_W-1:0] a_wait_q;
    logic [RAMP_CNT_W-1:0] b_wait_q;

    wire a_settled = (a_level_q == a_target);
    wire b_settled = (b_level_q == b_target);
    wire a_jump = (a_rate == RATE_IMMEDIATE);
    wire b_jump = (b_rate == RATE_IMMEDIATE);

    // The wait restarts while settled, so a fresh target gets one full step period first.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            a_level_q <= code_to_level(RST_A_MAIN[4:0]);
            b_level_q <= code_to_level(RST_B_MAIN[4:0]);
            a_wait_q <= '0;
            b_wait_q <= '0;
        end else begin
            if (a_jump) begin
                a_level_q <= a_target; // RULE_13
                a_wait_q <= '0;
            end else if (a_settled) begin
                a_wait_q <= step_wait(RAMP_A_BASE_CYCLES, a_rate);
            end else if (a_wait_q == '0) begin
                a_level_q <= step_toward(a_level_q, a_target); // RULE_13
                a_wait_q <= step_wait(RAMP_A_BASE_CYCLES, a_rate); // RULE_10
            end else begin
                a_wait_q <= a_wait_q - RAMP_CNT_W'(1);
            end
            if (b_jump) begin
                b_level_q <= b_target; // RULE_13
                b_wait_q <= '0;
            end else if (b_settled) begin
                b_wait_q <= step_wait(RAMP_B_BASE_CYCLES, b_rate);
            end else if (b_wait_q == '0) begin
                b_level_q <= step_toward(b_level_q, b_target); // RULE_13
                b_wait_q <= step_wait(RAMP_B_BASE_CYCLES, b_rate); // RULE_09
            end else begin
                b_wait_q <= b_wait_q - RAMP_CNT_W'(1);
            end
        end
    end

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            buck_a_on <= 1'b0;
            buck_a_ripple_pref <= 1'b0;
            buck_a_force_fixed_freq <= 1'b0;
            buck_a_idle_select <= 1'b0;
            buck_a_discharge <= 1'b0;
            buck_b_on <= 1'b0;
            buck_b_ripple_pref <= 1'b0;
            buck_b_force_fixed_freq <= 1'b0;
            buck_b_idle_select <= 1'b0;
            buck_b_discharge <= 1'b0;
            clock_phase_offset <= 2'h0;
        end else begin
            buck_a_on <= a_main_q[BIT_ON]; // RULE_01
            buck_b_on <= b_main_q[BIT_ON]; // RULE_01
            buck_a_ripple_pref <= a_main_q[BIT_RIPPLE]; // RULE_02
            buck_b_ripple_pref <= b_main_q[BIT_RIPPLE]; // RULE_02
            buck_a_force_fixed_freq <= a_main_q[BIT_FIXED] & ~a_idle; // RULE_03 RULE_12
            buck_b_force_fixed_freq <= b_main_q[BIT_FIXED] & ~b_idle; // RULE_03 RULE_12
            buck_a_idle_select <= a_idle; // RULE_12
            buck_b_idle_select <= b_idle; // RULE_12
            buck_a_discharge <= a_aux_q[BIT_DISCH]; // RULE_07
            buck_b_discharge <= b_aux_q[BIT_DISCH]; // RULE_07
            clock_phase_offset <= a_aux_q[PHASE_MSB:PHASE_LSB]; // RULE_08
        end
    end

    assign buck_a_level = a_level_q;
    assign buck_b_level = b_level_q;
endmodule

// file: verification/bcc_top_sva.sv
// Purpose: Port-level assertions for the buck converter control block.
// Assumes: Bound to bcc_top; sees only its ports.
// Notes: Register contents are checked by the bench through readback.
`timescale 1ns/1ps
module bcc_top_sva (
    input wire logic clock,
    input wire logic reset,
    input wire logic sda_out,
    input wire logic buck_a_on,
    input wire logic buck_b_on,
    input wire logic buck_a_force_fixed_freq,
    input wire logic buck_b_force_fixed_freq,
    input wire logic buck_a_idle_select,
    input wire logic buck_b_idle_select,
    input wire logic [4:0] buck_a_level,
    input wire logic [4:0] buck_b_level
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    // Idle forces pulse-frequency operation whatever the main register asks.
    property p_a_idle_pfm; buck_a_idle_select |-> !buck_a_force_fixed_freq; endproperty
    a_a_idle_pfm: assert property (p_a_idle_pfm) else $error("a fixed in idle");
    property p_b_idle_pfm; buck_b_idle_select |-> !buck_b_force_fixed_freq; endproperty
    a_b_idle_pfm: assert property (p_b_idle_pfm) else $error("b fixed in idle");
    property p_a_wrap; buck_a_level != 5'h1F; endproperty
    a_a_wrap: assert property (p_a_wrap) else $error("a level all ones");
    property p_b_wrap; buck_b_level != 5'h1F; endproperty
    a_b_wrap: assert property (p_b_wrap) else $error("b level all ones");
    // Even the fastest finite ramp leaves a settled cycle between steps.
    property p_a_step; $changed(buck_a_level) |=> $stable(buck_a_level); endproperty
    a_a_step: assert property (p_a_step) else $error("a level stepped twice");
    property p_b_step; $changed(buck_b_level) |=> $stable(buck_b_level); endproperty
    a_b_step: assert property (p_b_step) else $error("b level stepped twice");
    property p_rst_out; $fell(reset) |-> !buck_a_on && !buck_b_on && buck_a_level == 5'h10;
    endproperty
    a_rst_out: assert property (p_rst_out) else $error("bad state after reset");
    property p_open_drain; sda_out == 1'b0; endproperty
    a_open_drain: assert property (p_open_drain) else $error("data pin driven high");
endmodule
bind bcc_top bcc_top_sva chk (.clock(clock), .reset(reset), .sda_out(sda_out),
    .buck_a_on(buck_a_on), .buck_b_on(buck_b_on),
    .buck_a_force_fixed_freq(buck_a_force_fixed_freq),
    .buck_b_force_fixed_freq(buck_b_force_fixed_freq),
    .buck_a_idle_select(buck_a_idle_select), .buck_b_idle_select(buck_b_idle_select),
    .buck_a_level(buck_a_level), .buck_b_level(buck_b_level));

// file: verification/bcc_host_model.sv
// Purpose: Host side of the two-wire serial port for the buck control block.
// Assumes: Lines change only at falling clock edges, phases of eight clocks.
// Notes: Data changes four clocks after the serial clock falls to keep clear of starts.
`timescale 1ns/1ps
module bcc_host_model #(
    parameter logic [6:0] DEV_ADDR = 7'h2A
) (
    input wire logic clock,
    input wire logic sda_oe,
    output logic scl,
    output logic sda
);
    logic drv = 1'b1;
    initial scl = 1'b1;
    // Pulled-up line: released by both parties it reads high.
    assign sda = drv & ~sda_oe;
    task automatic ph(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic put(input logic b);
        ph(4);
        drv = b;
        ph(8);
        scl = 1'b1;
        ph(8);
        scl = 1'b0;
    endtask
    task automatic get(output logic b);
        ph(4);
        drv = 1'b1;
        ph(8);
        scl = 1'b1;
        ph(8);
        b = sda;
        scl = 1'b0;
    endtask
    // Data is raised with the serial clock low, then falls while the clock is high.
    task automatic start();
        ph(4);
        drv = 1'b1;
        ph(8);
        scl = 1'b1;
        ph(8);
        drv = 1'b0;
        ph(8);
        scl = 1'b0;
    endtask
    task automatic stop();
        ph(4);
        drv = 1'b0;
        ph(8);
        scl = 1'b1;
        ph(8);
        drv = 1'b1;
        ph(8);
    endtask
    task automatic put_byte(input logic [7:0] v);
        logic ack;
        for (int i = 7; i >= 0; i--) put(v[i]);
        get(ack);
    endtask
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        start();
        put_byte({DEV_ADDR, 1'b0});
        put_byte(a);
        put_byte(d);
        stop();
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        start();
        put_byte({DEV_ADDR, 1'b0});
        put_byte(a);
        start();
        put_byte({DEV_ADDR, 1'b1});
        for (int i = 7; i >= 0; i--) get(d[i]);
        put(1'b1);
        stop();
    endtask
endmodule

// file: verification/bcc_top_tb_top.sv
// Purpose: Self-checking bench for the buck converter control block.
// Assumes: Host model reaches the registers; ramp base shortened to 128 cycles.
// Notes: A slow ramp is sampled before its first step and after its last.
`timescale 1ns/1ps
module bcc_top_tb_top;
    localparam logic [6:0] DEV = 7'h2A; // Arbitrary device address.
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic scl, sda, sda_oe, a_on, a_rip, a_fix, a_idle, a_dis, b_on, b_rip, b_fix, b_idle, b_dis;
    logic [4:0] a_lvl, b_lvl;
    logic [1:0] phase;
    logic [7:0] rd;
    logic [7:0] rst_tbl [6] = '{8'h10, 8'h16, 8'h10, 8'h0A, 8'h06, 8'h0A};
    logic [7:0] mask_tbl [6] = '{8'hFF, 8'h7F, 8'h1F, 8'hFF, 8'h67, 8'h1F};
    int error_cnt = 0;
    int cmp_count = 0;
    bcc_top #(.DEV_ADDR(DEV), .RAMP_A_BASE_CYCLES(128), .RAMP_B_BASE_CYCLES(128)) uut (
        .clock(clock), .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
        .buck_a_on(a_on), .buck_a_ripple_pref(a_rip), .buck_a_force_fixed_freq(a_fix),
        .buck_a_idle_select(a_idle), .buck_a_discharge(a_dis), .buck_a_level(a_lvl),
        .buck_b_on(b_on), .buck_b_ripple_pref(b_rip), .buck_b_force_fixed_freq(b_fix),
        .buck_b_idle_select(b_idle), .buck_b_discharge(b_dis), .buck_b_level(b_lvl),
        .clock_phase_offset(phase));
    bcc_host_model #(.DEV_ADDR(DEV)) host (.clock(clock), .sda_oe(sda_oe), .scl(scl), .sda(sda));
    initial forever #5 clock = ~clock;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        host.read_reg(a, rd);
        check(rd, e);
    endtask
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clock);
        @(negedge clock);
        reset = 1'b0;
        repeat (4) @(negedge clock);
        check({1'b0, phase, a_lvl}, 8'h50);
        for (int i = 0; i < 6; i++) rd_chk(8'h10 + 8'(i), rst_tbl[i]);
        for (int i = 0; i < 6; i++) host.write_reg(8'h10 + 8'(i), 8'hFF);
        for (int i = 0; i < 6; i++) rd_chk(8'h10 + 8'(i), mask_tbl[i]);
        check({a_on, a_rip, a_fix, a_idle, a_dis, phase, 1'b0}, 8'hDE);
        check({b_on, b_rip, b_fix, b_idle, b_dis, 3'h0}, 8'hD8);
        check({a_lvl, b_lvl[2:0]}, 8'h00);
        for (int k = 0; k < 4; k++) begin
            host.write_reg(8'h11, {3'h0, 2'(k), 3'h7});
            check({6'h0, phase}, 8'(k));
        end
        check({a_fix, a_idle, a_dis, 5'h0}, 8'h80);
        host.write_reg(8'h10, 8'h0A);
        check({a_on, a_rip, a_fix, a_lvl}, 8'h0A);
        host.write_reg(8'h11, 8'h00);
        host.write_reg(8'h10, 8'h0C);
        check({3'h0, a_lvl}, 8'h0A);
        repeat (300) @(negedge clock);
        check({3'h0, a_lvl}, 8'h0C);
        host.write_reg(8'h15, 8'h03);
        host.write_reg(8'h14, 8'h47);
        check({b_fix, b_idle, 1'b0, b_lvl}, 8'h43);
        host.write_reg(8'h14, 8'h07);
        check({b_fix, b_idle, 1'b0, b_lvl}, 8'h80);
        rd_chk(8'h16, 8'h00);
        end_sim();
    end
    initial begin
        repeat (60000) @(posedge clock);
        error_cnt++;
        end_sim();
    end
endmodule
